// ==== common/fsbrq_pkg.sv ====
// Shared constants for the front-side bus request phase block.
// Assumes pins carry raw electrical levels; asserted means low.
package fsbrq_pkg;
	// ----------------------------------------------------------------
	// Field widths and positions
	// ----------------------------------------------------------------
	localparam int ADDR_MSB = 35;
	localparam int ADDR_LSB = 3;
	localparam int ADDR_W = ADDR_MSB - ADDR_LSB + 1;
	localparam int REQ_W = 5;
	localparam int LOW_GRP_MSB = 16;
	localparam int HIGH_GRP_LSB = 17;
	localparam int LOW_GRP_W = LOW_GRP_MSB - ADDR_LSB + 1;
	localparam int HIGH_GRP_W = ADDR_MSB - HIGH_GRP_LSB + 1;
	localparam int PAR_SPLIT = 24;
	localparam int PAR_W = 2;
	// Bus-clock cycles from the sampled strobe to stable captured lines.
	localparam logic [1:0] RX_WAIT = 2'h3;
	// Transmit sequencer states, one bus clock each except idle.
	typedef enum logic [2:0] {
		TX_IDLE = 3'h0,
		TX_SUB1_DATA = 3'h1,
		TX_SUB1_EDGE = 3'h2,
		TX_SUB2_DATA = 3'h3,
		TX_SUB2_EDGE = 3'h4
	} fsbrq_tx_e;
endpackage

// ==== verilog/fsbrq_request_phase.sv ====
// Request and address phase of a front-side bus agent, device side.
// Assumes the bench resolves each shared wire from the enables and
// feeds the resolved level back on the matching _in port.
// Functional notes
// - Address-20 mask is asynchronous; synchronise it before any use.
// - Initiator asserts transaction strobe when address and type are valid.
// - Seeing the transaction strobe starts checking and decode of the transaction.
// - Lines are captured on both edges of the driver's address strobes.
// - Strobe 0 carries type and address 16:3; strobe 1 carries 35:17.
// - Parity lines are driven together with strobe, address and type.
// - Parity line is high when an even number of covered lines are low.
// - Subphase 1: lane0 covers 35:24, lane1 the rest; subphase 2 swaps.
// - Bus clock launches all bus outputs and latches common-clock inputs.
`timescale 1ns/1ps
`default_nettype none
module fsbrq_request_phase (
	// Core clock and control.
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clkEn,
	// Bus clock, true half of the differential pair.
	input wire logic diff_bus_clock_true,
	// Request issue, core domain.
	input wire logic reqValid,
	input wire logic [fsbrq_pkg::ADDR_W-1:0] reqAddr,
	input wire logic [fsbrq_pkg::REQ_W-1:0] reqType,
	output logic reqReady,
	// Observed transactions, core domain.
	output logic rxValid,
	output logic [fsbrq_pkg::ADDR_W-1:0] rxAddr,
	output logic [fsbrq_pkg::REQ_W-1:0] rxType,
	output logic rxParityErr,
	// Address-20 mask.
	input wire logic addr_bit20_mask_n,
	output logic a20MaskActive,
	// Transaction strobe pin.
	input wire logic txn_addr_strobe_in_n,
	output logic txn_addr_strobe_out_n,
	output logic txn_addr_strobe_oe_n,
	// Address and type pins.
	input wire logic [fsbrq_pkg::ADDR_W-1:0] addr_in_n,
	output logic [fsbrq_pkg::ADDR_W-1:0] addr_out_n,
	input wire logic [fsbrq_pkg::REQ_W-1:0] req_in_n,
	output logic [fsbrq_pkg::REQ_W-1:0] req_out_n,
	output logic addr_oe_n,
	// Source-synchronous strobes.
	input wire logic low_addr_strobe_in_n,
	output logic low_addr_strobe_out_n,
	input wire logic high_addr_strobe_in_n,
	output logic high_addr_strobe_out_n,
	output logic strobe_oe_n,
	// Parity pins.
	input wire logic [fsbrq_pkg::PAR_W-1:0] address_parity_in_n,
	output logic [fsbrq_pkg::PAR_W-1:0] address_parity_out_n,
	output logic address_parity_oe_n
);
	// ----------------------------------------------------------------
	// Parity helper
	// ----------------------------------------------------------------
	// Pin-level parity: high when the count of low lines is even.
	function automatic logic parityPin(input logic [fsbrq_pkg::ADDR_W+
			fsbrq_pkg::REQ_W-1:0] v, input logic [fsbrq_pkg::ADDR_W+
			fsbrq_pkg::REQ_W-1:0] m);
		parityPin = ~(^(~v & m));
	endfunction
	localparam int VW = fsbrq_pkg::ADDR_W + fsbrq_pkg::REQ_W;
	// Coverage masks over {address 35:3, type 4:0}.
	localparam logic [VW-1:0] UPPER_MASK = {{(fsbrq_pkg::ADDR_MSB -
		fsbrq_pkg::PAR_SPLIT + 1){1'b1}}, {(fsbrq_pkg::PAR_SPLIT -
		fsbrq_pkg::ADDR_LSB + fsbrq_pkg::REQ_W){1'b0}}};
	localparam logic [VW-1:0] LOWER_MASK = ~UPPER_MASK;
	// Expected pin parity for a subphase, lanes swapped in subphase 2.
	function automatic logic [1:0] expectPar(input logic [VW-1:0] v,
			input logic sub2);
		logic pu;
		logic pl;
		pu = parityPin(v, UPPER_MASK);
		pl = parityPin(v, LOWER_MASK);
		expectPar = sub2 ? {pu, pl} : {pl, pu};
	endfunction

	// ----------------------------------------------------------------
	// Core domain: mask synchroniser and request handshake
	// ----------------------------------------------------------------
	logic a20Sync1, a20Sync2;
	logic reqToggle, ackSync1, ackSync2;
	logic rxTogSync1, rxTogSync2, rxTogSeen;
	logic [fsbrq_pkg::ADDR_W-1:0] holdAddr;
	logic [fsbrq_pkg::REQ_W-1:0] holdType;
	logic next_reqToggle, next_reqReady, next_rxValid;
	logic [fsbrq_pkg::ADDR_W-1:0] next_holdAddr;
	logic [fsbrq_pkg::REQ_W-1:0] next_holdType;
	logic ackToggle, rxToggle, rxErrBus;
	logic [fsbrq_pkg::ADDR_W-1:0] rxAddrBus;
	logic [fsbrq_pkg::REQ_W-1:0] rxTypeBus;

	// A request is taken only while idle; the held copy stays still
	// until the bus side answers, so it can be read across domains.
	always_comb begin
		next_reqToggle = reqToggle;
		next_holdAddr = holdAddr;
		next_holdType = holdType;
		if (reqValid && reqReady) begin
			next_reqToggle = ~reqToggle;
			next_holdAddr = reqAddr;
			next_holdType = reqType;
		end
		// Only the second flop of the acknowledge synchroniser is read,
		// so a metastable first stage never reaches the ready logic.
		next_reqReady = (next_reqToggle == ackSync2);
		next_rxValid = (rxTogSync2 != rxTogSeen);
	end

	// Core registers; the mask passes two flops before the output.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			a20Sync1 <= 1'b1;
			a20Sync2 <= 1'b1;
			a20MaskActive <= 1'b0;
			reqToggle <= 1'b0;
			ackSync1 <= 1'b0;
			ackSync2 <= 1'b0;
			reqReady <= 1'b0;
			holdAddr <= '0;
			holdType <= '0;
			rxTogSync1 <= 1'b0;
			rxTogSync2 <= 1'b0;
			rxTogSeen <= 1'b0;
			rxValid <= 1'b0;
			rxAddr <= '0;
			rxType <= '0;
			rxParityErr <= 1'b0;
		end else if (clkEn) begin
			a20Sync1 <= addr_bit20_mask_n;
			a20Sync2 <= a20Sync1;
			a20MaskActive <= ~a20Sync2;
			reqToggle <= next_reqToggle;
			ackSync1 <= ackToggle;
			ackSync2 <= ackSync1;
			reqReady <= next_reqReady;
			holdAddr <= next_holdAddr;
			holdType <= next_holdType;
			rxTogSync1 <= rxToggle;
			rxTogSync2 <= rxTogSync1;
			rxTogSeen <= rxTogSync2;
			rxValid <= next_rxValid;
			if (next_rxValid) begin
				rxAddr <= rxAddrBus;
				rxType <= rxTypeBus;
				rxParityErr <= rxErrBus;
			end
		end
	end

	// ----------------------------------------------------------------
	// Bus domain: transmit sequencer
	// ----------------------------------------------------------------
	fsbrq_pkg::fsbrq_tx_e txState, next_txState;
	logic reqSync1, reqSync2, reqSeen, next_reqSeen, next_ackToggle;
	logic next_ads, next_oe, next_lowStb;
	logic [VW-1:0] txPins;

	assign txPins = {~holdAddr, ~holdType};

	// Each subphase holds data for one clock, then moves the strobe,
	// giving a full bus clock of setup and hold around every edge.
	always_comb begin
		next_txState = txState;
		next_reqSeen = reqSeen;
		next_ackToggle = ackToggle;
		case (txState)
			fsbrq_pkg::TX_IDLE: begin
				if (reqSync2 != reqSeen) begin
					next_txState = fsbrq_pkg::TX_SUB1_DATA;
					next_reqSeen = reqSync2;
				end
			end
			fsbrq_pkg::TX_SUB1_DATA: next_txState = fsbrq_pkg::TX_SUB1_EDGE;
			fsbrq_pkg::TX_SUB1_EDGE: next_txState = fsbrq_pkg::TX_SUB2_DATA;
			fsbrq_pkg::TX_SUB2_DATA: next_txState = fsbrq_pkg::TX_SUB2_EDGE;
			fsbrq_pkg::TX_SUB2_EDGE: begin
				next_txState = fsbrq_pkg::TX_IDLE;
				next_ackToggle = ~ackToggle;
			end
			default: next_txState = fsbrq_pkg::TX_IDLE;
		endcase
		next_ads = (next_txState != fsbrq_pkg::TX_SUB1_DATA);
		next_oe = (next_txState == fsbrq_pkg::TX_IDLE);
		next_lowStb = !(next_txState == fsbrq_pkg::TX_SUB1_EDGE ||
			next_txState == fsbrq_pkg::TX_SUB2_DATA);
	end

	// All bus outputs launch from the bus clock.
	always_ff @(posedge diff_bus_clock_true or negedge reset_n) begin
		if (!reset_n) begin
			txState <= fsbrq_pkg::TX_IDLE;
			reqSync1 <= 1'b0;
			reqSync2 <= 1'b0;
			reqSeen <= 1'b0;
			ackToggle <= 1'b0;
			txn_addr_strobe_out_n <= 1'b1;
			txn_addr_strobe_oe_n <= 1'b1;
			addr_oe_n <= 1'b1;
			strobe_oe_n <= 1'b1;
			address_parity_oe_n <= 1'b1;
			addr_out_n <= '1;
			req_out_n <= '1;
			low_addr_strobe_out_n <= 1'b1;
			high_addr_strobe_out_n <= 1'b1;
			address_parity_out_n <= '1;
		end else begin
			txState <= next_txState;
			reqSync1 <= reqToggle;
			reqSync2 <= reqSync1;
			reqSeen <= next_reqSeen;
			ackToggle <= next_ackToggle;
			txn_addr_strobe_out_n <= next_ads;
			txn_addr_strobe_oe_n <= next_oe;
			addr_oe_n <= next_oe;
			strobe_oe_n <= next_oe;
			address_parity_oe_n <= next_oe;
			addr_out_n <= next_oe ? '1 : txPins[VW-1:fsbrq_pkg::REQ_W];
			req_out_n <= next_oe ? '1 : txPins[fsbrq_pkg::REQ_W-1:0];
			// Both strobes move together so each group sees both edges.
			low_addr_strobe_out_n <= next_lowStb;
			high_addr_strobe_out_n <= next_lowStb;
			address_parity_out_n <= next_oe ? '1 : expectPar(txPins,
				next_txState >= fsbrq_pkg::TX_SUB2_DATA);
		end
	end

	// ----------------------------------------------------------------
	// Strobe-edge capture and receive check
	// ----------------------------------------------------------------
	localparam int LOW_GRP_IDX = fsbrq_pkg::LOW_GRP_W - 1;
	logic [fsbrq_pkg::REQ_W+fsbrq_pkg::LOW_GRP_W-1:0] capLowA, capLowB;
	logic [fsbrq_pkg::HIGH_GRP_W-1:0] capHighA, capHighB;
	logic [fsbrq_pkg::PAR_W-1:0] capParA, capParB;

	// Strobe 0 qualifies type and low address; falling edge is
	// subphase 1, rising edge subphase 2.
	always_ff @(negedge low_addr_strobe_in_n or negedge reset_n) begin
		if (!reset_n) begin
			capLowA <= '1;
			capParA <= '1;
		end else begin
			capLowA <= {req_in_n, addr_in_n[LOW_GRP_IDX:0]};
			capParA <= address_parity_in_n;
		end
	end
	always_ff @(posedge low_addr_strobe_in_n or negedge reset_n) begin
		if (!reset_n) begin
			capLowB <= '1;
			capParB <= '1;
		end else begin
			capLowB <= {req_in_n, addr_in_n[LOW_GRP_IDX:0]};
			capParB <= address_parity_in_n;
		end
	end
	// Strobe 1 qualifies the high address group on both edges.
	always_ff @(negedge high_addr_strobe_in_n or negedge reset_n) begin
		if (!reset_n) begin
			capHighA <= '1;
		end else begin
			capHighA <= addr_in_n[fsbrq_pkg::ADDR_W-1:LOW_GRP_IDX+1];
		end
	end
	always_ff @(posedge high_addr_strobe_in_n or negedge reset_n) begin
		if (!reset_n) begin
			capHighB <= '1;
		end else begin
			capHighB <= addr_in_n[fsbrq_pkg::ADDR_W-1:LOW_GRP_IDX+1];
		end
	end

	logic adsSample;
	logic [1:0] rxCount, next_rxCount;
	logic next_rxToggle, next_rxErr;
	logic [VW-1:0] subA, subB;

	assign subA = {capHighA, capLowA[LOW_GRP_IDX:0],
		capLowA[fsbrq_pkg::REQ_W+LOW_GRP_IDX:LOW_GRP_IDX+1]};
	assign subB = {capHighB, capLowB[LOW_GRP_IDX:0],
		capLowB[fsbrq_pkg::REQ_W+LOW_GRP_IDX:LOW_GRP_IDX+1]};

	// The sampled strobe starts a wait until both strobe edges have
	// landed; captured lines are then stable for the bus clock to read.
	always_comb begin
		next_rxCount = rxCount;
		next_rxToggle = rxToggle;
		next_rxErr = rxErrBus;
		if (!adsSample) begin
			next_rxCount = fsbrq_pkg::RX_WAIT;
		end else if (rxCount != 2'h0) begin
			next_rxCount = rxCount - 2'h1;
		end
		if (rxCount == 2'h1 && adsSample) begin
			next_rxToggle = ~rxToggle;
			next_rxErr = (expectPar(subA, 1'b0) != capParA) ||
				(expectPar(subB, 1'b1) != capParB);
		end
	end

	// The transaction strobe is a common-clock input latched on the bus clock.
	always_ff @(posedge diff_bus_clock_true or negedge reset_n) begin
		if (!reset_n) begin
			adsSample <= 1'b1;
			rxCount <= 2'h0;
			rxToggle <= 1'b0;
			rxErrBus <= 1'b0;
			rxAddrBus <= '0;
			rxTypeBus <= '0;
		end else begin
			adsSample <= txn_addr_strobe_in_n;
			rxCount <= next_rxCount;
			rxToggle <= next_rxToggle;
			rxErrBus <= next_rxErr;
			if (next_rxToggle != rxToggle) begin
				rxAddrBus <= ~subA[VW-1:fsbrq_pkg::REQ_W];
				rxTypeBus <= ~subA[fsbrq_pkg::REQ_W-1:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	sequence adsStart;
		$fell(txn_addr_strobe_out_n);
	endsequence
	sequence strobeWalk;
		low_addr_strobe_out_n ##1 !low_addr_strobe_out_n [*2]
			##1 low_addr_strobe_out_n;
	endsequence
	adsSingle_a: assert property (@(posedge diff_bus_clock_true)
		disable iff (!reset_n) adsStart |=> txn_addr_strobe_out_n [*3])
		else $error("transaction strobe held longer than one clock");
	strobeEdges_a: assert property (@(posedge diff_bus_clock_true)
		disable iff (!reset_n) adsStart |-> strobeWalk)
		else $error("address strobe sequence wrong");
	strobeTied_a: assert property (@(posedge diff_bus_clock_true)
		disable iff (!reset_n)
		low_addr_strobe_out_n == high_addr_strobe_out_n)
		else $error("address strobes differ");
	parityDrive_a: assert property (@(posedge diff_bus_clock_true)
		disable iff (!reset_n) adsStart |-> !address_parity_oe_n [*4]
		##1 address_parity_oe_n && addr_oe_n)
		else $error("parity not driven with address");
	paritySub1_a: assert property (@(posedge diff_bus_clock_true)
		disable iff (!reset_n) adsStart |-> address_parity_out_n ==
		expectPar({addr_out_n, req_out_n}, 1'b0))
		else $error("subphase one parity wrong");
	paritySwap_a: assert property (@(posedge diff_bus_clock_true)
		disable iff (!reset_n) adsStart |-> ##2 address_parity_out_n ==
		{$past(address_parity_out_n[0], 2),
		$past(address_parity_out_n[1], 2)})
		else $error("subphase two parity lanes not swapped");
	rxStart_a: assert property (@(posedge diff_bus_clock_true)
		disable iff (!reset_n) !adsSample |-> ##4 rxToggle !=
		$past(rxToggle))
		else $error("observed transaction not checked");
	maskSync_a: assert property (@(posedge clk) disable iff (!reset_n)
		clkEn [*3] |=> a20MaskActive ==
		!$past(addr_bit20_mask_n, 3))
		else $error("mask not passed through two flops");
	busClocked_a: assert property (@(posedge clk) disable iff (!reset_n)
		rxValid |-> $past(rxTogSync2) != $past(rxTogSeen))
		else $error("received word without bus event");
endmodule
`default_nettype wire

// ==== test/fsbrq_far_agent.sv ====
// Far-side bus agent model that issues request phases at the pins.
// Assumes the bench resolves shared wires with pull-ups to high.
`timescale 1ns/1ps
`default_nettype none
module fsbrq_far_agent (
	// Bus clock and control.
	input wire logic bclk,
	input wire logic reset_n,
	input wire logic go,
	input wire logic strobeOnly,
	input wire logic badPar,
	input wire logic [fsbrq_pkg::ADDR_W-1:0] addr,
	input wire logic [fsbrq_pkg::REQ_W-1:0] typ,
	// Pin drive, high when released.
	output logic oe_n,
	output logic txn_n,
	output logic [fsbrq_pkg::ADDR_W-1:0] addr_n,
	output logic [fsbrq_pkg::REQ_W-1:0] req_n,
	output logic stb_n,
	output logic [1:0] par_n,
	output logic busy
);
	// ----------------------------------------------------------------
	// Phase sequencer
	// ----------------------------------------------------------------
	logic [2:0] st;
	logic pHi;
	logic pLo;
	// An even count of low pins gives a high parity pin.
	assign pHi = ~^addr[32:21];
	assign pLo = ~(^addr[20:0] ^ ^typ);
	assign busy = (st != 3'h0);
	// One phase per bus clock, launched on the bus clock only.
	always_ff @(posedge bclk or negedge reset_n) begin
		if (!reset_n)
			st <= 3'h0;
		else if (st == 3'h4)
			st <= 3'h0;
		else if (st != 3'h0 || go)
			st <= st + 3'h1;
	end
	// Released lines float high, so stale values never linger.
	assign oe_n = (st == 3'h0);
	assign txn_n = !(st == 3'h1 && !strobeOnly);
	assign stb_n = !(st == 3'h2 || st == 3'h3);
	assign addr_n = oe_n ? '1 : ~addr;
	assign req_n = oe_n ? '1 : ~typ;
	// Bad-parity mode flips lane 0 in subphase 1 only.
	assign par_n = oe_n ? 2'h3 : (st >= 3'h3) ? {pHi, pLo} :
		{pLo, pHi ^ badPar};
endmodule
`default_nettype wire

// ==== test/fsbrq_request_phase_tb.sv ====
// Self-checking bench for the request phase block.
// Assumes the far agent model and pull-ups on every shared wire.
`timescale 1ns/1ps
`default_nettype none
module fsbrq_request_phase_tb;
	// ----------------------------------------------------------------
	// Signals and wire resolution
	// ----------------------------------------------------------------
	logic clk = 1'b0, bclk = 1'b0, reset_n = 1'b0, reqValid = 1'b0;
	logic [32:0] reqAddr = '0, rxAddr, dAddr, fAddr = '0, fAddrN, addrW;
	logic [4:0] reqType = '0, rxType, dReq, fTyp = '0, fReq, reqW;
	logic [1:0] dPar, fPar, parW;
	logic maskN = 1'b1;
	logic clkEn = 1'b1;
	logic go = 1'b0, sOnly = 1'b0, bad = 1'b0, fOe, fTxn, fStb, fBusy;
	logic reqReady, rxValid, rxParityErr, a20, dTxn, dTxnOe, dAddrOe;
	logic dLo, dHi, dStbOe, dParOe, txnW, loW, hiW;
	int miscompares = 0;
	int checks = 0;
	initial forever #2 clk = ~clk;
	// Bus clock phase is offset from the core clock on purpose.
	initial begin
		#3.3;
		forever #7.5 bclk = ~bclk;
	end
	// Wired-AND of both drivers; the far model already floats high.
	assign txnW = (dTxn | dTxnOe) & fTxn;
	assign addrW = (dAddr | {33{dAddrOe}}) & fAddrN;
	assign reqW = (dReq | {5{dAddrOe}}) & fReq;
	assign loW = (dLo | dStbOe) & fStb;
	assign hiW = (dHi | dStbOe) & fStb;
	assign parW = (dPar | {2{dParOe}}) & fPar;
	fsbrq_request_phase DUT (.clk(clk), .reset_n(reset_n), .clkEn(clkEn),
		.diff_bus_clock_true(bclk), .reqValid(reqValid), .reqAddr(reqAddr),
		.reqType(reqType), .reqReady(reqReady), .rxValid(rxValid),
		.rxAddr(rxAddr), .rxType(rxType), .rxParityErr(rxParityErr),
		.addr_bit20_mask_n(maskN), .a20MaskActive(a20),
		.txn_addr_strobe_in_n(txnW), .txn_addr_strobe_out_n(dTxn),
		.txn_addr_strobe_oe_n(dTxnOe), .addr_in_n(addrW), .addr_out_n(dAddr),
		.req_in_n(reqW), .req_out_n(dReq), .addr_oe_n(dAddrOe),
		.low_addr_strobe_in_n(loW), .low_addr_strobe_out_n(dLo),
		.high_addr_strobe_in_n(hiW), .high_addr_strobe_out_n(dHi),
		.strobe_oe_n(dStbOe), .address_parity_in_n(parW),
		.address_parity_out_n(dPar), .address_parity_oe_n(dParOe));
	fsbrq_far_agent FAR (.bclk(bclk), .reset_n(reset_n), .go(go),
		.strobeOnly(sOnly), .badPar(bad), .addr(fAddr), .typ(fTyp),
		.oe_n(fOe), .txn_n(fTxn), .addr_n(fAddrN), .req_n(fReq),
		.stb_n(fStb), .par_n(fPar), .busy(fBusy));
	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [39:0] seen, input logic [39:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("checks=%0d miscompares=%0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Pin levels of both parity lanes, lane 0 in bit 0.
	function automatic logic [1:0] expPar(input logic [32:0] a,
		input logic [4:0] t, input logic sub2);
		logic hi;
		logic lo;
		hi = ~^a[32:21];
		lo = ~(^a[20:0] ^ ^t);
		return sub2 ? {hi, lo} : {lo, hi};
	endfunction
	// Bounded wait for the one-cycle delivery pulse.
	task automatic waitRx(output logic got);
		got = 1'b0;
		for (int i = 0; i < 300 && !got; i++) begin
			@(posedge clk);
			#1 got = (rxValid === 1'b1);
		end
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	// Own request: watch every phase at the wire, then the loop-back.
	task automatic tOwn(input logic [32:0] a, input logic [4:0] t);
		logic got;
		for (int i = 0; i < 300 && reqReady !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		reqAddr = a;
		reqType = t;
		reqValid = 1'b1;
		@(posedge clk);
		#1 reqValid = 1'b0;
		fork
			begin
				for (int i = 0; i < 100 && txnW !== 1'b0; i++)
					@(negedge bclk);
				check({addrW, reqW}, {~a, ~t});
				check({loW, hiW, parW}, {2'h3, expPar(a, t, 0)});
				@(negedge bclk);
				check({txnW, loW, hiW, parW}, {3'h4, expPar(a, t, 0)});
				@(negedge bclk);
				check({loW, hiW, parW}, {2'h0, expPar(a, t, 1)});
				@(negedge bclk);
				check({loW, hiW}, 2'h3);
				@(negedge bclk);
				check({dAddrOe, dParOe, dStbOe, dTxnOe}, 4'hF);
			end
			waitRx(got);
		join
		check({got, rxAddr, rxType, rxParityErr}, {1'b1, a, t, 1'b0});
	endtask
	// Far-side request, with a parity fault when b is set.
	task automatic tFar(input logic [32:0] a, input logic [4:0] t,
		input logic b, input logic ghost);
		logic got;
		fAddr = a;
		fTyp = t;
		bad = b;
		sOnly = ghost;
		go = 1'b1;
		@(posedge fBusy);
		#1 go = 1'b0;
		waitRx(got);
		if (ghost)
			check(got, 1'b0);
		else
			check({got, rxAddr, rxType, rxParityErr}, {1'b1, a, t, b});
		sOnly = 1'b0;
	endtask
	// The mask must pass a synchroniser before it shows.
	task automatic tMask();
		@(posedge clk);
		#1 maskN = 1'b0;
		@(posedge clk);
		#1 check(a20, 1'b0);
		repeat (4) @(posedge clk);
		#1 check(a20, 1'b1);
		maskN = 1'b1;
		repeat (5) @(posedge clk);
		#1 check(a20, 1'b0);
		// A low enable freezes the synchroniser; it resumes afterwards.
		clkEn = 1'b0;
		maskN = 1'b0;
		repeat (5) @(posedge clk);
		#1 check(a20, 1'b0);
		clkEn = 1'b1;
		repeat (4) @(posedge clk);
		#1 check(a20, 1'b1);
		maskN = 1'b1;
	endtask
	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		repeat (5) @(posedge clk);
		repeat (2) @(posedge bclk);
		#1 check({reqReady, rxValid, dTxnOe, dAddrOe, dStbOe, dParOe}, 6'h0F);
		@(posedge clk);
		#1 reset_n = 1'b1;
		tOwn(33'h0_0000_0000, 5'h00);
		tOwn(33'h1_2345_6789, 5'h15);
		tFar(33'h1_0F0F_0F0F, 5'h0A, 1'b0, 1'b0);
		tFar(33'h0_ABCD_1234, 5'h1F, 1'b1, 1'b0);
		tFar(33'h1_FFFF_FFFF, 5'h1F, 1'b0, 1'b0);
		tFar(33'h0_5555_AAAA, 5'h03, 1'b0, 1'b1);
		tMask();
		conclude();
	end
	// Whole run should finish in well under this span.
	initial begin
		#20000;
		miscompares++;
		conclude();
	end
endmodule
`default_nettype wire
